// File: rtl/nvm_ctrl_host.sv
// Processor end: runs read and write sequences
`timescale 1ns/1ps
`default_nettype none
module nvm_ctrl_host (
  input wire logic sys_clk,
  input wire logic sys_rst,
  nvm_sfr_if.host bus,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic busy
);
  import nvm_pkg::*;

  // ====================
  // Sequencer states
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_AHI = 4'h1, S_ALO = 4'h2, S_DAT = 4'h3,
    S_PTR = 4'h4, S_BANK = 4'h5, S_GOFF = 4'h6, S_ARM = 4'h7,
    S_START = 4'h8, S_GON = 4'h9, S_POLL = 4'hA, S_WAIT = 4'hB,
    S_CHK = 4'hC, S_CLR = 4'hD, S_UNBANK = 4'hE, S_GET = 4'hF
  } state_t;

  state_t state_q;               // Sequencer state
  logic is_read_q;               // Current job is a read
  logic got_q;                   // Data fetch issued after read
  logic [ADDR_W-1:0] addr_q;     // Target address
  logic [7:0] wbyte_q;           // Byte to store
  logic [7:0] result_q;          // Last byte read
  logic done_q;                  // Job finished
  logic [7:0] irq_cnt_q;         // Serviced interrupts
  logic [7:0] a_q;               // Bus address
  logic [7:0] d_q;               // Bus write data
  logic wr_q;                    // Bus write strobe
  logic rd_q;                    // Bus read strobe
  logic ack_q;                   // Interrupt service pulse
  logic [7:0] rdata_q;           // User read data
  logic [7:0] arm_byte;          // Arm pattern for current job
  logic [7:0] start_byte;        // Start pattern for current job
  logic start_bit;               // Start bit polled

  assign bus.sfr_addr = a_q;
  assign bus.sfr_wdata = d_q;
  assign bus.sfr_wr = wr_q;
  assign bus.sfr_rd = rd_q;
  assign bus.irq_ack = ack_q;
  assign bus.stack_full = 1'b0;
  assign busy = (state_q != S_IDLE);
  assign reg_rdata = rdata_q;
  assign arm_byte = is_read_q ? 8'h02 : 8'h08;
  assign start_byte = is_read_q ? 8'h03 : 8'h0C;
  assign start_bit = is_read_q ? bus.sfr_rdata[FETCH_START_BIT]
                               : bus.sfr_rdata[PROG_START_BIT];

  // ====================
  // User registers; commands refused while busy
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      addr_q <= '0;
      wbyte_q <= 8'h00;
    end else if (reg_wr && !busy) begin
      if (reg_addr == HREG_ADDR_LOW) begin
        addr_q[7:0] <= reg_wdata;
      end else if (reg_addr == HREG_ADDR_HIGH) begin
        addr_q[ADDR_W-1:8] <= reg_wdata[HI_W-1:0];
      end else if (reg_addr == HREG_WDATA) begin
        wbyte_q <= reg_wdata;
      end
    end
  end

  // User read data, one cycle after strobe
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !reg_rd) begin
      rdata_q <= 8'h00;
    end else if (reg_addr == HREG_CMD) begin
      rdata_q <= {6'h00, done_q, busy};
    end else if (reg_addr == HREG_ADDR_LOW) begin
      rdata_q <= addr_q[7:0];
    end else if (reg_addr == HREG_ADDR_HIGH) begin
      rdata_q <= {{(8-HI_W){1'b0}}, addr_q[ADDR_W-1:8]};
    end else if (reg_addr == HREG_WDATA) begin
      rdata_q <= wbyte_q;
    end else if (reg_addr == HREG_RESULT) begin
      rdata_q <= result_q;
    end else if (reg_addr == HREG_IRQ_COUNT) begin
      rdata_q <= irq_cnt_q;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ====================
  // Interrupt service: one ack per request, counted
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      irq_cnt_q <= 8'h00;
    end else begin
      ack_q <= bus.vector_req && !ack_q;
      if (bus.vector_req && !ack_q) begin
        irq_cnt_q <= irq_cnt_q + 8'h01;
      end
    end
  end

  // ====================
  // Sequencer: at most one bus access per state, strobes one cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= S_IDLE;
      is_read_q <= 1'b0;
      got_q <= 1'b0;
      done_q <= 1'b0;
      result_q <= 8'h00;
      a_q <= 8'h00;
      d_q <= 8'h00;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          // Accept a command
          if (reg_wr && reg_addr == HREG_CMD && (reg_wdata == CMD_WRITE
              || reg_wdata == CMD_READ)) begin
            is_read_q <= (reg_wdata == CMD_READ);
            got_q <= 1'b0;
            done_q <= 1'b0;
            state_q <= S_AHI;
          end
        end
        S_AHI: begin
          // Address and data loaded first
          wr_q <= 1'b1;
          a_q <= SFR_ADDR_HIGH;
          d_q <= {{(8-HI_W){1'b0}}, addr_q[ADDR_W-1:8]};
          state_q <= S_ALO;
        end
        S_ALO: begin
          wr_q <= 1'b1;
          a_q <= SFR_ADDR_LOW;
          d_q <= addr_q[7:0];
          state_q <= is_read_q ? S_PTR : S_DAT;
        end
        S_DAT: begin
          wr_q <= 1'b1;
          a_q <= SFR_DATA;
          d_q <= wbyte_q;
          state_q <= S_PTR;
        end
        S_PTR: begin
          wr_q <= 1'b1;
          a_q <= SFR_INDIRECT_PTR;
          d_q <= CTRL_PTR;
          state_q <= S_BANK;
        end
        S_BANK: begin
          wr_q <= 1'b1;
          a_q <= SFR_BANK_SELECT;
          d_q <= CTRL_BANK;
          state_q <= is_read_q ? S_ARM : S_GOFF;
        end
        S_GOFF: begin
          // Global off, memory enable on
          wr_q <= 1'b1;
          a_q <= SFR_IRQ_CTRL;
          d_q <= 8'h02;
          state_q <= S_ARM;
        end
        S_ARM: begin
          wr_q <= 1'b1;
          a_q <= SFR_INDIRECT_PORT;
          d_q <= arm_byte;
          state_q <= S_START;
        end
        S_START: begin
          // Directly after arm, one start bit only
          wr_q <= 1'b1;
          a_q <= SFR_INDIRECT_PORT;
          d_q <= start_byte;
          state_q <= is_read_q ? S_POLL : S_GON;
        end
        S_GON: begin
          wr_q <= 1'b1;
          a_q <= SFR_IRQ_CTRL;
          d_q <= 8'h03;
          state_q <= S_POLL;
        end
        S_POLL: begin
          rd_q <= 1'b1;
          a_q <= SFR_INDIRECT_PORT;
          state_q <= S_WAIT;
        end
        S_WAIT: begin
          state_q <= S_CHK;
        end
        S_CHK: begin
          if (got_q) begin
            result_q <= bus.sfr_rdata;
            done_q <= 1'b1;
            state_q <= S_IDLE;
          end else if (start_bit) begin
            state_q <= S_POLL;
          end else begin
            state_q <= S_CLR;
          end
        end
        S_CLR: begin
          wr_q <= 1'b1;
          a_q <= SFR_INDIRECT_PORT;
          d_q <= BYTE_ZERO;
          state_q <= S_UNBANK;
        end
        S_UNBANK: begin
          wr_q <= 1'b1;
          a_q <= SFR_BANK_SELECT;
          d_q <= BANK_RESET;
          if (is_read_q) begin
            state_q <= S_GET;
          end else begin
            done_q <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_GET: begin
          // Fetch result from the data register
          rd_q <= 1'b1;
          a_q <= SFR_DATA;
          got_q <= 1'b1;
          state_q <= S_WAIT;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: rtl/nvm_pkg.sv
// Shared constants for the memory controller and its host
package nvm_pkg;
  // ====================
  // Memory geometry
  localparam int DATA_W = 8;
  localparam int ADDR_W = 10;
  localparam int DEPTH = 1024;
  localparam int HI_W = ADDR_W - 8;
  // ====================
  // Special function register offsets
  localparam logic [7:0] SFR_ADDR_LOW = 8'h01;
  localparam logic [7:0] SFR_ADDR_HIGH = 8'h02;
  localparam logic [7:0] SFR_DATA = 8'h03;
  localparam logic [7:0] SFR_INDIRECT_PORT = 8'h04;
  localparam logic [7:0] SFR_INDIRECT_PTR = 8'h05;
  localparam logic [7:0] SFR_BANK_SELECT = 8'h06;
  localparam logic [7:0] SFR_IRQ_CTRL = 8'h07;
  // Control register location in bank 1
  localparam logic [7:0] CTRL_PTR = 8'h40;
  localparam logic [7:0] CTRL_BANK = 8'h01;
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // ====================
  // Control register bits
  localparam int FETCH_START_BIT = 0;
  localparam int FETCH_ARM_BIT = 1;
  localparam int PROG_START_BIT = 2;
  localparam int PROG_ARM_BIT = 3;
  // Interrupt control bits
  localparam int GIE_BIT = 0;
  localparam int NIE_BIT = 1;
  localparam int NIF_BIT = 2;
  // ====================
  // Write timer: own time base
  localparam int CLK_PERIOD_NS = 100;
  localparam int TIMER_PERIOD_NS = 3200;
  localparam int TIMER_DIV = (TIMER_PERIOD_NS + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;
  localparam logic [5:0] TIMER_LAST = 6'(TIMER_DIV - 1);
  localparam logic [3:0] PROG_TICKS_LAST = 4'h7;
  // ====================
  // Host user register offsets and commands
  localparam logic [2:0] HREG_CMD = 3'h0;
  localparam logic [2:0] HREG_ADDR_LOW = 3'h1;
  localparam logic [2:0] HREG_ADDR_HIGH = 3'h2;
  localparam logic [2:0] HREG_WDATA = 3'h3;
  localparam logic [2:0] HREG_RESULT = 3'h4;
  localparam logic [2:0] HREG_IRQ_COUNT = 3'h5;
  localparam logic [7:0] CMD_WRITE = 8'h01;
  localparam logic [7:0] CMD_READ = 8'h02;
endpackage

// File: rtl/nvm_sfr_if.sv
// Register bus between processor and controller
`timescale 1ns/1ps
`default_nettype none
interface nvm_sfr_if;
  logic [7:0] sfr_addr;   // Register offset
  logic [7:0] sfr_wdata;  // Write data
  logic sfr_wr;           // One-cycle write strobe
  logic sfr_rd;           // One-cycle read strobe
  logic [7:0] sfr_rdata;  // Read data, cycle after strobe
  logic vector_req;       // Memory interrupt branch request
  logic irq_ack;          // Interrupt serviced pulse
  logic stack_full;       // Call stack full level
  modport device (
    input sfr_addr, sfr_wdata, sfr_wr, sfr_rd, irq_ack, stack_full,
    output sfr_rdata, vector_req
  );
  modport host (
    output sfr_addr, sfr_wdata, sfr_wr, sfr_rd, irq_ack, stack_full,
    input sfr_rdata, vector_req
  );
endinterface
`default_nettype wire

// File: rtl/nvm_ctrl_device.sv
// Data memory controller end
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Software loads address and data first
// - Arm then start write back to back
// - Write start ignored unless arm set
// - Global interrupts off around write start
// - Write timed by independent internal timer
// - Hardware clears write start when done
// - Software polls start bit or interrupt
// - Write arm cleared at reset
// - Bank select resets to zero
// - Interrupt flag set at write end
// - Software sets memory interrupt enable
// - Branch needs both enables, stack free
// - Flag cleared when interrupt serviced
// - No halt during pending access
// - Keep arm clear, bank zero idle
// - Optional read back verification
// - Pointer 040H, bank 01H for control
// - Read: arm bit1, start bit0, poll
// - Write: arm bit3, start bit2, poll
// - Clear control and bank afterwards
// - Never both start bits together
// - 1024 bytes, ten address bits
// - Read result held until next access
module nvm_ctrl_device (
  input wire logic sys_clk,
  input wire logic sys_rst,
  nvm_sfr_if.device bus,
  output logic busy
);
  import nvm_pkg::*;

  // ====================
  // Storage
  logic [DATA_W-1:0] mem [DEPTH];     // Byte array
  logic [7:0] addr_low_q;             // Address bits 7..0
  logic [HI_W-1:0] addr_high_q;       // Address bits 9..8
  logic [DATA_W-1:0] data_q;          // Data register
  logic [7:0] ptr_q;                  // Indirect pointer
  logic [7:0] bank_q;                 // Bank select
  logic prog_arm_q;                   // Write arm bit
  logic prog_start_q;                 // Write start / busy bit
  logic fetch_arm_q;                  // Read arm bit
  logic fetch_start_q;                // Read start bit
  logic gie_q;                        // Global interrupt enable
  logic nie_q;                        // Memory interrupt enable
  logic nif_q;                        // Memory interrupt flag
  logic [ADDR_W-1:0] prog_addr_q;     // Address latched at write start
  logic [DATA_W-1:0] prog_data_q;     // Data latched at write start
  logic [5:0] timer_q;                // Free running timer prescaler
  logic [3:0] prog_cnt_q;             // Timer ticks into write cycle
  logic [7:0] rdata_q;                // Read data register

  // ====================
  // Decode
  logic [ADDR_W-1:0] cur_addr;        // Address from the two registers
  logic ctrl_sel;                     // Indirect port reaches control
  logic wr_ctrl;                      // Write to control register
  logic [7:0] wd;                     // Write data shorthand
  logic tick;                         // Timer tick
  logic prog_go;                      // Accepted write start
  logic fetch_go;                     // Accepted read start
  logic prog_done;                    // Write cycle ends this cycle

  assign wd = bus.sfr_wdata;
  assign cur_addr = {addr_high_q, addr_low_q};
  // Control register visible only at bank 1, pointer 40h
  assign ctrl_sel = (bank_q == CTRL_BANK) && (ptr_q == CTRL_PTR);
  assign wr_ctrl = bus.sfr_wr && (bus.sfr_addr == SFR_INDIRECT_PORT)
                   && ctrl_sel;
  // Start needs arm already set; both starts together are refused
  assign prog_go = wr_ctrl && wd[PROG_START_BIT] && prog_arm_q
                   && !prog_start_q && !fetch_start_q
                   && !wd[FETCH_START_BIT];
  assign fetch_go = wr_ctrl && wd[FETCH_START_BIT] && fetch_arm_q
                    && !fetch_start_q && !prog_start_q
                    && !wd[PROG_START_BIT];
  assign tick = (timer_q == TIMER_LAST);
  assign prog_done = prog_start_q && tick
                     && (prog_cnt_q == PROG_TICKS_LAST);
  assign busy = prog_start_q || fetch_start_q;

  // ====================
  // Plain registers written by software
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      addr_low_q <= 8'h00;
      addr_high_q <= '0;
      ptr_q <= 8'h00;
      bank_q <= BANK_RESET;
      gie_q <= 1'b0;
      nie_q <= 1'b0;
    end else if (bus.sfr_wr) begin
      // Address decode
      if (bus.sfr_addr == SFR_ADDR_LOW) begin
        addr_low_q <= wd;
      end else if (bus.sfr_addr == SFR_ADDR_HIGH) begin
        addr_high_q <= wd[HI_W-1:0];
      end else if (bus.sfr_addr == SFR_INDIRECT_PTR) begin
        ptr_q <= wd;
      end else if (bus.sfr_addr == SFR_BANK_SELECT) begin
        bank_q <= wd;
      end else if (bus.sfr_addr == SFR_IRQ_CTRL) begin
        gie_q <= wd[GIE_BIT];
        nie_q <= wd[NIE_BIT];
      end
    end
  end

  // ====================
  // Data register: read result wins over software write
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      data_q <= '0;
    end else if (fetch_start_q) begin
      // Read completes one cycle after start, then holds
      data_q <= mem[cur_addr];
    end else if (bus.sfr_wr && (bus.sfr_addr == SFR_DATA)) begin
      data_q <= wd;
    end
  end

  // ====================
  // Arm bits follow control writes
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prog_arm_q <= 1'b0;
      fetch_arm_q <= 1'b0;
    end else if (wr_ctrl) begin
      prog_arm_q <= wd[PROG_ARM_BIT];
      fetch_arm_q <= wd[FETCH_ARM_BIT];
    end
  end

  // ====================
  // Write start bit: set on accepted start, cleared by hardware at end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prog_start_q <= 1'b0;
    end else if (prog_done) begin
      prog_start_q <= 1'b0;
    end else if (prog_go) begin
      prog_start_q <= 1'b1;
    end
  end

  // Read start bit: one cycle read, then self clears
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fetch_start_q <= 1'b0;
    end else if (fetch_start_q) begin
      fetch_start_q <= 1'b0;
    end else if (fetch_go) begin
      fetch_start_q <= 1'b1;
    end
  end

  // ====================
  // Latch target at start so later register changes cannot corrupt it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prog_addr_q <= '0;
      prog_data_q <= '0;
    end else if (prog_go) begin
      prog_addr_q <= cur_addr;
      prog_data_q <= data_q;
    end
  end

  // ====================
  // Free running prescaler: start phase unrelated to write timing
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      timer_q <= 6'h00;
    end else if (tick) begin
      timer_q <= 6'h00;
    end else begin
      timer_q <= timer_q + 6'h01;
    end
  end

  // Tick counter for the write cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prog_cnt_q <= 4'h0;
    end else if (prog_go) begin
      prog_cnt_q <= 4'h0;
    end else if (prog_start_q && tick) begin
      prog_cnt_q <= prog_cnt_q + 4'h1;
    end
  end

  // ====================
  // Memory array written at the end of the write cycle
  always_ff @(posedge sys_clk) begin
    if (prog_done) begin
      mem[prog_addr_q] <= prog_data_q;
    end
  end

  // ====================
  // Interrupt flag: set wins over service and software clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      nif_q <= 1'b0;
    end else if (prog_done) begin
      nif_q <= 1'b1;
    end else if (bus.irq_ack) begin
      nif_q <= 1'b0;
    end else if (bus.sfr_wr && (bus.sfr_addr == SFR_IRQ_CTRL)) begin
      nif_q <= wd[NIF_BIT];
    end
  end

  // Branch request needs both enables and room on the stack
  assign bus.vector_req = nif_q && gie_q && nie_q
                          && !bus.stack_full;

  // ====================
  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (!bus.sfr_rd) begin
      rdata_q <= 8'h00;
    end else if (bus.sfr_addr == SFR_ADDR_LOW) begin
      rdata_q <= addr_low_q;
    end else if (bus.sfr_addr == SFR_ADDR_HIGH) begin
      rdata_q <= {{(8-HI_W){1'b0}}, addr_high_q};
    end else if (bus.sfr_addr == SFR_DATA) begin
      rdata_q <= data_q;
    end else if (bus.sfr_addr == SFR_INDIRECT_PORT && ctrl_sel) begin
      // Busy bit reads one until write ends
      rdata_q <= {4'h0, prog_arm_q, prog_start_q,
                  fetch_arm_q, fetch_start_q};
    end else if (bus.sfr_addr == SFR_INDIRECT_PTR) begin
      rdata_q <= ptr_q;
    end else if (bus.sfr_addr == SFR_BANK_SELECT) begin
      rdata_q <= bank_q;
    end else if (bus.sfr_addr == SFR_IRQ_CTRL) begin
      rdata_q <= {5'h00, nif_q, nie_q, gie_q};
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign bus.sfr_rdata = rdata_q;
endmodule
`default_nettype wire

// File: verification/nvm_ctrl_sva.sv
// Checker on the register bus between the ends
`timescale 1ns/1ps
`default_nettype none
module nvm_ctrl_sva
  import nvm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic vector_req,
  input wire logic irq_ack,
  input wire logic stack_full
);
  // ====================
  // Shadow of bus traffic
  logic [7:0] ptr_q; // Pointer as last written
  logic [7:0] bank_q; // Bank as last written
  logic [7:0] irqc_q; // Interrupt control as last written
  logic [11:0] wcnt_q; // Cycles since write start, 0 when idle
  logic port_wr; // Write to the indirect port
  logic start_w; // Write start request
  assign port_wr = sfr_wr && sfr_addr == SFR_INDIRECT_PORT;
  assign start_w = port_wr && sfr_wdata[PROG_START_BIT];
  // Track pointer, bank and interrupt control writes
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ptr_q <= 8'h00;
      bank_q <= 8'h00;
      irqc_q <= 8'h00;
    end else if (sfr_wr) begin
      if (sfr_addr == SFR_INDIRECT_PTR) ptr_q <= sfr_wdata;
      if (sfr_addr == SFR_BANK_SELECT) bank_q <= sfr_wdata;
      if (sfr_addr == SFR_IRQ_CTRL) irqc_q <= sfr_wdata;
    end
  end
  // Count cycles of a write until software tidies up
  always_ff @(posedge sys_clk) begin
    if (sys_rst) wcnt_q <= 12'h000;
    else if (start_w) wcnt_q <= 12'h001;
    else if (port_wr && sfr_wdata == BYTE_ZERO) wcnt_q <= 12'h000;
    else if (wcnt_q != 12'h000 && wcnt_q != 12'hFFF) wcnt_q <= wcnt_q + 12'h001;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ====================
  // Properties
  property p_arm_first;
    start_w |-> $past(port_wr) && $past(sfr_wdata) == 8'h08;
  endproperty
  a_arm_first: assert property (p_arm_first)
    else $error("start without arm");
  property p_one_start;
    port_wr |-> !(sfr_wdata[FETCH_START_BIT] && sfr_wdata[PROG_START_BIT]);
  endproperty
  a_one_start: assert property (p_one_start)
    else $error("both starts");
  property p_ptr_bank;
    port_wr |-> ptr_q == CTRL_PTR && bank_q == CTRL_BANK;
  endproperty
  a_ptr_bank: assert property (p_ptr_bank)
    else $error("port without bank");
  property p_gie_off;
    start_w |-> !irqc_q[GIE_BIT];
  endproperty
  a_gie_off: assert property (p_gie_off)
    else $error("gie on at start");
  property p_gie_back;
    start_w |=> sfr_wr && sfr_addr == SFR_IRQ_CTRL && sfr_wdata[GIE_BIT];
  endproperty
  a_gie_back: assert property (p_gie_back)
    else $error("global enable not restored");
  property p_branch;
    vector_req |-> irqc_q[GIE_BIT] && irqc_q[NIE_BIT] && !stack_full;
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch without enables");
  property p_ack_clears;
    irq_ack |=> !vector_req;
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("flag kept after service");
  property p_write_busy;
    $past(sfr_rd) && $past(sfr_addr) == SFR_INDIRECT_PORT
      && wcnt_q > 12'h001 && wcnt_q < 12'h0DC |-> sfr_rdata[PROG_START_BIT];
  endproperty
  a_write_busy: assert property (p_write_busy)
    else $error("start bit dropped");
  property p_write_ends;
    wcnt_q < 12'h12C;
  endproperty
  a_write_ends: assert property (p_write_ends)
    else $error("write never finished");
  property p_rdata_idle;
    !$past(sfr_rd) |-> sfr_rdata == BYTE_ZERO;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("stray read data");
  property p_tidy;
    port_wr && sfr_wdata == BYTE_ZERO |-> ##[1:3] (sfr_wr
      && sfr_addr == SFR_BANK_SELECT && sfr_wdata == BANK_RESET);
  endproperty
  a_tidy: assert property (p_tidy)
    else $error("bank not cleared");
endmodule
`default_nettype wire

// File: verification/eeprom_data_access_ctrl_tb.sv
// Testbench for both controller ends
`timescale 1ns/1ps
`default_nettype none
module eeprom_data_access_ctrl_tb;
  import nvm_pkg::*;
  logic sys_clk;
  logic sys_rst;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic host_busy;
  logic dev_busy;
  logic dev2_busy;
  int err_count;
  int n_checks;
  int cyc;
  int irq_exp;
  logic [7:0] mdl [int]; // Expected memory content
  logic [9:0] aq [$]; // Addresses under test
  nvm_sfr_if bus_a();
  nvm_sfr_if bus_b();
  nvm_ctrl_device nvm_ctrl_device_inst (.sys_clk, .sys_rst, .bus(bus_a),
    .busy(dev_busy));
  nvm_ctrl_host nvm_ctrl_host_inst (.sys_clk, .sys_rst, .bus(bus_a),
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .busy(host_busy));
  nvm_ctrl_device nvm_ctrl_device_inst2 (.sys_clk, .sys_rst, .bus(bus_b),
    .busy(dev2_busy));
  nvm_ctrl_sva nvm_ctrl_sva_inst (.sys_clk, .sys_rst,
    .sfr_addr(bus_a.sfr_addr), .sfr_wdata(bus_a.sfr_wdata),
    .sfr_wr(bus_a.sfr_wr), .sfr_rd(bus_a.sfr_rd),
    .sfr_rdata(bus_a.sfr_rdata), .vector_req(bus_a.vector_req),
    .irq_ack(bus_a.irq_ack), .stack_full(bus_a.stack_full));
  // ====================
  // Clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  // ====================
  // Shared tasks
  task wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Host user port write and read
  task automatic hwr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic hrd(input logic [2:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic hrchk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    hrd(a, v);
    chk(v, e);
  endtask
  // Direct register bus cycles on the second device
  task automatic sw(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_b.sfr_addr <= a;
    bus_b.sfr_wdata <= d;
    bus_b.sfr_wr <= 1'b1;
    @(posedge sys_clk);
    bus_b.sfr_wr <= 1'b0;
  endtask
  task automatic sr(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    bus_b.sfr_addr <= a;
    bus_b.sfr_rd <= 1'b1;
    @(posedge sys_clk);
    bus_b.sfr_rd <= 1'b0;
    #1 v = bus_b.sfr_rdata;
  endtask
  task automatic srchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    sr(a, v);
    chk(v, e);
  endtask
  // One host command run to completion
  task automatic hop(input logic [7:0] cmd, input logic [9:0] a,
                     input logic [7:0] d);
    logic [7:0] v;
    int k;
    hwr(HREG_ADDR_HIGH, {6'h00, a[9:8]});
    hwr(HREG_ADDR_LOW, a[7:0]);
    hwr(HREG_WDATA, d);
    hwr(HREG_CMD, cmd);
    hrchk(HREG_CMD, 8'h01);
    k = 0;
    v = 8'h00;
    while (v !== 8'h02 && k < 500) begin
      hrd(HREG_CMD, v);
      k++;
    end
    chk(v, 8'h02);
    chk({6'h00, host_busy, dev_busy}, 8'h00);
  endtask
  // ====================
  // Main sequence
  initial begin
    logic [7:0] v;
    logic [7:0] d;
    int k;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {bus_b.sfr_addr, bus_b.sfr_wdata, bus_b.sfr_wr, bus_b.sfr_rd} = '0;
    bus_b.irq_ack = 1'b0;
    bus_b.stack_full = 1'b0;
    sys_rst = 1'b1;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    void'($urandom(32'h3250));
    // Protection after reset, refused starts
    srchk(SFR_BANK_SELECT, BANK_RESET);
    sw(SFR_INDIRECT_PTR, CTRL_PTR);
    sw(SFR_INDIRECT_PORT, 8'h0A);
    sw(SFR_BANK_SELECT, CTRL_BANK);
    srchk(SFR_INDIRECT_PORT, 8'h00);
    sw(SFR_INDIRECT_PORT, 8'h04);
    srchk(SFR_INDIRECT_PORT, 8'h00);
    sw(SFR_INDIRECT_PORT, 8'h0C);
    srchk(SFR_INDIRECT_PORT, 8'h08);
    sw(SFR_INDIRECT_PORT, 8'h0A);
    sw(SFR_INDIRECT_PORT, 8'h0F);
    srchk(SFR_INDIRECT_PORT, 8'h0A);
    // Write with interrupt, start held while busy
    sw(SFR_ADDR_LOW, 8'h5A);
    sw(SFR_ADDR_HIGH, 8'h03);
    sw(SFR_DATA, 8'hC3);
    sw(SFR_IRQ_CTRL, 8'h02);
    sw(SFR_INDIRECT_PORT, 8'h08);
    sw(SFR_INDIRECT_PORT, 8'h0C);
    sw(SFR_IRQ_CTRL, 8'h03);
    chk({7'h00, dev2_busy}, 8'h01);
    sw(SFR_INDIRECT_PORT, 8'h08);
    srchk(SFR_INDIRECT_PORT, 8'h0C);
    k = 0;
    v = 8'h04;
    while (v[PROG_START_BIT] !== 1'b0 && k < 400) begin
      sr(SFR_INDIRECT_PORT, v);
      k++;
    end
    chk(v, 8'h08);
    chk({7'h00, bus_b.vector_req}, 8'h01);
    bus_b.stack_full <= 1'b1;
    @(posedge sys_clk);
    #1 chk({7'h00, bus_b.vector_req}, 8'h00);
    bus_b.stack_full <= 1'b0;
    bus_b.irq_ack <= 1'b1;
    @(posedge sys_clk);
    bus_b.irq_ack <= 1'b0;
    #1 chk({7'h00, bus_b.vector_req}, 8'h00);
    // Read back through the fetch bits
    sw(SFR_INDIRECT_PORT, 8'h02);
    sw(SFR_INDIRECT_PORT, 8'h03);
    srchk(SFR_INDIRECT_PORT, 8'h02);
    srchk(SFR_DATA, 8'hC3);
    // Host writes at edge and random addresses, then reads
    aq = '{10'h3FF, 10'h0FF, 10'h000, 10'h100};
    repeat (4) aq.push_back(10'($urandom_range(1023)));
    foreach (aq[i]) begin
      d = 8'($urandom);
      mdl[aq[i]] = d;
      irq_exp++;
      hop(CMD_WRITE, aq[i], d);
      hrchk(HREG_IRQ_COUNT, 8'(irq_exp));
    end
    foreach (aq[i]) begin
      hop(CMD_READ, aq[i], 8'h00);
      hrchk(HREG_RESULT, mdl[aq[i]]);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
